// file: hw/dcpq_top.sv
// Two channel latching relay coil pulse qualifier with an AHB-Lite register slave.
//
// Function
// [R1] Lockout and overtemperature override enable and switch both coils off.
// [R2] A command starts only on a rising edge of its input.
// [R3] Pulses shorter than the qualification time are dropped without output.
// [R4] Coil switches on once the input stayed high past the qualification time.
// [R5] Fixed mode gives maximum width; otherwise output copies input high width.
// [R6] Other input rising during qualification holds result pending; short one ignored.
// [R7] Both inputs qualified together, or overlapping qualification, give no pulse.
// [R8] During a coil pulse, rising edges on the other input are discarded.
// [R9] A coil output never stays on beyond the maximum on-time.
// [R10] Default maximum on-time is 150 ms from pulse start.
// [R11] A permanently high input gets one capped pulse, then output stays off.
// [R12] Two identical independent channels, each input to its own coil; this design shares one sequencer, so the channels interlock.
// [R13] Default qualification time is 15 ms.
// [R14] Coil outputs are open drain: sink when on, released when off.
// [R15] Fixed mode holds the coil on for exactly the maximum on-time.
// [R16] Enable low releases both coils and returns control to idle.
// [R17] Enable level changes act only after about 5 us of filtering.
// [R18] Under lockout both coils stay released whatever the other inputs do.
// [R19] Times and mode are build-time constants counted in clock cycles.
// [R20] Commands and enable are synchronised before edge detection and counting.
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module dcpq_top #(
  parameter int unsigned QUAL_CYCLES   = dcpq_pkg::QUAL_CYCLES,    // [R13]
  parameter int unsigned MAX_ON_CYCLES = dcpq_pkg::MAX_ON_CYCLES,  // [R10]
  parameter bit          FIXED_MODE    = 1'b0,
  parameter int unsigned FILT_CYCLES   = dcpq_pkg::ENABLE_FILT_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        command_input_a,
  input  wire logic        command_input_b,
  input  wire logic        enable_in,
  input  wire logic        supply_low_lockout,
  input  wire logic        overtemp_shutdown,
  input  wire logic        coil_drive_a_in,
  output logic             coil_drive_a_out,
  output logic             coil_drive_a_oe_n,
  input  wire logic        coil_drive_b_in,
  output logic             coil_drive_b_out,
  output logic             coil_drive_b_oe_n
);

  localparam int unsigned W = dcpq_pkg::CNT_W;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    dcpq_pkg::dcpq_state_t        state;
    logic                         drive_ch;
    logic                         tailing;
    logic [1:0]                   qualifying;
    logic [1:0]                   cmd_prev;
    logic [1:0][W-1:0]            qcnt;
    logic [W-1:0]                 ocnt;
    logic                         soft_en;
    logic [dcpq_pkg::EV_W-1:0]    events;
    logic                         ap_valid;
    logic                         ap_write;
    logic [11:0]                  ap_addr;
    logic                         hreadyout;
    logic [31:0]                  hrdata;
    logic                         hresp;
    logic [1:0]                   coil_oe_n;
    logic [1:0]                   coil_out;
  } dcpq_core_t;

  localparam dcpq_core_t CORE_RST = '{
    state:     dcpq_pkg::ST_ARM,
    soft_en:   dcpq_pkg::CTRL_SOFT_EN_RST,
    hreadyout: 1'b1,
    coil_oe_n: 2'b11,
    default:   '0
  };

  dcpq_core_t                q;
  dcpq_core_t                d;
  logic [1:0]                rise;
  logic [1:0]                qdone;
  logic                      run;
  logic                      start;
  logic                      start_ch;
  logic                      p;
  logic                      o;
  logic                      end_pulse;
  logic [dcpq_pkg::EV_W-1:0] ev;
  logic [dcpq_pkg::EV_W-1:0] clr;

  dcpq_pin_if pins ();

  // ------------------------------------------------------------------
  // Pin conditioning
  // ------------------------------------------------------------------
  // Raw pins enter the conditioner; channel a is index 0, channel b index 1.
  assign pins.cmd_raw      = {command_input_b, command_input_a};  // [R12]
  assign pins.enable_raw   = enable_in;
  assign pins.lockout_raw  = supply_low_lockout;
  assign pins.overtemp_raw = overtemp_shutdown;
  assign pins.readback_raw = {coil_drive_b_in, coil_drive_a_in};

  dcpq_pin_cond #(
    .FILT_CYCLES (FILT_CYCLES)
  ) u_pin_cond (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (pins)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // True when a cycle counter has reached its limit.
  function automatic logic dcpq_reached(input logic [W-1:0] cnt, input int unsigned lim);
    return cnt == W'(lim);  // [R19]
  endfunction

  // Read mux over the register map, taken from the next state.
  function automatic logic [31:0] dcpq_read(input logic [11:0] a, input dcpq_core_t s,
                                            input logic [4:0] pin_st);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == dcpq_pkg::CTRL_OFFSET)
    begin
      r[dcpq_pkg::CTRL_SOFT_EN_BIT] = s.soft_en;
    end
    else if (a == dcpq_pkg::STATUS_OFFSET)
    begin
      r[dcpq_pkg::ST_COIL_LSB +: 2] = ~s.coil_oe_n;
      r[dcpq_pkg::ST_QUAL_LSB +: 2] = s.qualifying;
      r[dcpq_pkg::ST_PENDING_BIT]   = s.state == dcpq_pkg::ST_PENDING;
      r[dcpq_pkg::ST_REJECT_BIT]    = s.state == dcpq_pkg::ST_REJECT;
      r[dcpq_pkg::ST_ENABLE_BIT +: 3] = pin_st[2:0];
      r[dcpq_pkg::ST_PIN_LSB +: 2]  = pin_st[4:3];
      r[dcpq_pkg::ST_FIXED_BIT]     = FIXED_MODE;
    end
    else if (a == dcpq_pkg::EVENTS_OFFSET)
    begin
      r[dcpq_pkg::EV_W-1:0] = s.events;
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Control and bus logic
  // ------------------------------------------------------------------
  // Next state of the qualifier, the coil drivers and the register slave.
  always_comb
  begin
    d         = q;
    rise      = pins.cmd & ~q.cmd_prev;  // [R2]
    qdone     = 2'b00;
    start     = 1'b0;
    start_ch  = 1'b0;
    p         = q.drive_ch;
    o         = ~q.drive_ch;
    end_pulse = 1'b0;
    ev        = '0;
    clr       = '0;
    run       = pins.enable_ok & ~pins.lockout & ~pins.overtemp & q.soft_en;  // [R1]
    d.cmd_prev = pins.cmd;
    d.hresp    = 1'b0;

    // Data phase of a write updates the addressed register.
    if (q.ap_valid && q.ap_write)
    begin
      if (q.ap_addr == dcpq_pkg::CTRL_OFFSET)
      begin
        d.soft_en = hwdata[dcpq_pkg::CTRL_SOFT_EN_BIT];
      end
      if (q.ap_addr == dcpq_pkg::EVENTS_OFFSET)
      begin
        clr = hwdata[dcpq_pkg::EV_W-1:0];
      end
    end

    // Qualification counting, one counter per channel.
    if (q.state == dcpq_pkg::ST_ARM || q.state == dcpq_pkg::ST_PENDING)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (q.qualifying[i])
        begin
          if (!pins.cmd[i])
          begin
            d.qualifying[i] = 1'b0;  // [R3]
            ev[dcpq_pkg::EV_SHORT] = 1'b1;
          end
          else if (dcpq_reached(q.qcnt[i], QUAL_CYCLES))
          begin
            d.qualifying[i] = 1'b0;
            qdone[i] = 1'b1;  // [R4]
          end
          else
          begin
            d.qcnt[i] = q.qcnt[i] + 1'b1;
          end
        end
        else if (rise[i] && !(q.state == dcpq_pkg::ST_PENDING && q.drive_ch == 1'(i)))
        begin
          d.qualifying[i] = 1'b1;  // [R2]
          d.qcnt[i] = W'(1);
        end
      end
    end

    // Sequencing between the two channels.
    unique case (q.state)
      dcpq_pkg::ST_ARM:
      begin
        if (qdone == 2'b11)
        begin
          d.state = dcpq_pkg::ST_REJECT;  // [R7]
          ev[dcpq_pkg::EV_XOR] = 1'b1;
        end
        else if (qdone != 2'b00)
        begin
          if (d.qualifying[~qdone[1]])
          begin
            d.state    = dcpq_pkg::ST_PENDING;  // [R6]
            d.drive_ch = qdone[1];
          end
          else
          begin
            start    = 1'b1;
            start_ch = qdone[1];
          end
        end
      end
      dcpq_pkg::ST_PENDING:
      begin
        if (qdone[o])
        begin
          d.state = dcpq_pkg::ST_REJECT;  // [R7]
          ev[dcpq_pkg::EV_XOR] = 1'b1;
        end
        else if (!d.qualifying[o])
        begin
          // Short intruder: a follow command whose input fell is dropped.
          if (FIXED_MODE || pins.cmd[p])
          begin
            start    = 1'b1;  // [R6]
            start_ch = p;
          end
          else
          begin
            d.state = dcpq_pkg::ST_ARM;
          end
        end
      end
      dcpq_pkg::ST_DRIVE:
      begin
        d.qualifying = 2'b00;
        if (rise[o])
        begin
          ev[dcpq_pkg::EV_OVERLAP] = 1'b1;  // [R8]
        end
        d.ocnt = q.ocnt + 1'b1;
        if (dcpq_reached(q.ocnt, MAX_ON_CYCLES))
        begin
          end_pulse = 1'b1;  // [R9] [R11] [R15]
          ev[dcpq_pkg::EV_MAXCUT] = pins.cmd[p] & ~q.tailing;
        end
        else if (!FIXED_MODE)
        begin
          // Follow mode: hold on for one qualification time after the fall.
          if (q.tailing)
          begin
            end_pulse = dcpq_reached(q.qcnt[p], QUAL_CYCLES);  // [R5]
            d.qcnt[p] = q.qcnt[p] + 1'b1;
          end
          else if (!pins.cmd[p])
          begin
            d.tailing = 1'b1;  // [R5]
            d.qcnt[p] = W'(1);
          end
        end
        if (end_pulse)
        begin
          d.state     = dcpq_pkg::ST_ARM;
          d.coil_oe_n = 2'b11;
          d.tailing   = 1'b0;
        end
      end
      dcpq_pkg::ST_REJECT:
      begin
        d.qualifying = 2'b00;
        if (pins.cmd == 2'b00)
        begin
          d.state = dcpq_pkg::ST_ARM;
        end
      end
    endcase

    // Launch a coil pulse on one channel only.
    if (start)
    begin
      d.state               = dcpq_pkg::ST_DRIVE;
      d.drive_ch            = start_ch;
      d.qualifying          = 2'b00;
      d.tailing             = 1'b0;
      d.ocnt                = W'(1);
      d.coil_oe_n           = 2'b11;
      d.coil_oe_n[start_ch] = 1'b0;  // [R14]
    end

    // Disable, lockout and overtemperature dominate everything else.
    if (!run)
    begin
      d.state      = dcpq_pkg::ST_ARM;  // [R16]
      d.qualifying = 2'b00;
      d.tailing    = 1'b0;
      d.coil_oe_n  = 2'b11;  // [R1] [R18]
    end

    // Sticky events; a new event wins over its clear.
    d.events   = (q.events & ~clr) | ev;
    d.coil_out = 2'b00;  // [R14]

    // Address phase capture; read data for the data phase.
    d.ap_valid  = hsel & htrans[1] & hready;
    d.ap_write  = hwrite;
    d.ap_addr   = haddr[11:0];
    d.hreadyout = 1'b1;
    d.hrdata    = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      d.hrdata = dcpq_read(haddr[11:0], d,
                           {pins.readback, pins.overtemp, pins.lockout, pins.enable_ok});
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= CORE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign hreadyout         = q.hreadyout;
  assign hrdata            = q.hrdata;
  assign hresp             = q.hresp;
  assign coil_drive_a_out  = q.coil_out[0];
  assign coil_drive_a_oe_n = q.coil_oe_n[0];
  assign coil_drive_b_out  = q.coil_out[1];
  assign coil_drive_b_oe_n = q.coil_oe_n[1];

endmodule

// file: inc/dcpq_pkg.sv
// Constants, register map and state type of the dual coil pulse qualifier.
package dcpq_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned QUAL_TIME_US    = 15000;
  localparam int unsigned MAX_ON_TIME_US  = 150000;
  localparam int unsigned ENABLE_FILT_NS  = 5000;
  // Least times round up, and every count is at least one cycle.
  localparam int unsigned QUAL_CYCLES     = QUAL_TIME_US * CLK_MHZ;
  localparam int unsigned MAX_ON_CYCLES   = MAX_ON_TIME_US * CLK_MHZ;
  localparam int unsigned ENABLE_FILT_CYCLES =
    (ENABLE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ENABLE_FILT_W   = 11;
  localparam int unsigned CNT_W           = 32;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] STATUS_OFFSET   = 12'h004;
  localparam logic [11:0] EVENTS_OFFSET   = 12'h008;

  // Control fields and reset values.
  localparam int unsigned CTRL_SOFT_EN_BIT = 0;
  localparam logic        CTRL_SOFT_EN_RST = 1'b1;

  // Status fields.
  localparam int unsigned ST_COIL_LSB     = 0;
  localparam int unsigned ST_QUAL_LSB     = 2;
  localparam int unsigned ST_PENDING_BIT  = 4;
  localparam int unsigned ST_REJECT_BIT   = 5;
  localparam int unsigned ST_ENABLE_BIT   = 6;
  localparam int unsigned ST_LOCKOUT_BIT  = 7;
  localparam int unsigned ST_OVERTEMP_BIT = 8;
  localparam int unsigned ST_PIN_LSB      = 9;
  localparam int unsigned ST_FIXED_BIT    = 11;

  // Sticky event fields, write one to clear.
  localparam int unsigned EV_SHORT        = 0;
  localparam int unsigned EV_XOR          = 1;
  localparam int unsigned EV_OVERLAP      = 2;
  localparam int unsigned EV_MAXCUT       = 3;
  localparam int unsigned EV_W            = 4;

  // ------------------------------------------------------------------
  // Control state machine
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ST_ARM, ST_PENDING, ST_DRIVE, ST_REJECT} dcpq_state_t;

endpackage

// file: inc/dcpq_pin_if.sv
// Carrier between the pin conditioner and the control core.
`timescale 1ns/1ps
interface dcpq_pin_if;
  logic [1:0] cmd_raw;
  logic       enable_raw;
  logic       lockout_raw;
  logic       overtemp_raw;
  logic [1:0] readback_raw;
  logic [1:0] cmd;
  logic       enable_ok;
  logic       lockout;
  logic       overtemp;
  logic [1:0] readback;

  modport conditioner (
    input  cmd_raw, enable_raw, lockout_raw, overtemp_raw, readback_raw,
    output cmd, enable_ok, lockout, overtemp, readback
  );
  modport core (
    output cmd_raw, enable_raw, lockout_raw, overtemp_raw, readback_raw,
    input  cmd, enable_ok, lockout, overtemp, readback
  );
endinterface

// file: hw/dcpq_pin_cond.sv
// Pin synchronisers and the enable input filter.
`timescale 1ns/1ps
module dcpq_pin_cond #(
  parameter int unsigned FILT_CYCLES = dcpq_pkg::ENABLE_FILT_CYCLES
) (
  input wire logic            hclk,
  input wire logic            hresetn,
  dcpq_pin_if.conditioner     pins
);

  typedef struct packed {
    logic [6:0]                         s1;
    logic [6:0]                         s2;
    logic                               en_filt;
    logic [dcpq_pkg::ENABLE_FILT_W-1:0] fcnt;
  } dcpq_cond_t;

  dcpq_cond_t q;
  dcpq_cond_t d;

  // Two flops per pin; only the second stage is read below.
  always_comb
  begin
    d = q;
    d.s1 = {pins.readback_raw, pins.overtemp_raw, pins.lockout_raw,
            pins.enable_raw, pins.cmd_raw};
    d.s2 = q.s1;
    // The enable level changes only after it has differed for the filter time.
    if (q.s2[2] != q.en_filt)
    begin
      if (q.fcnt == dcpq_pkg::ENABLE_FILT_W'(FILT_CYCLES - 1))
      begin
        d.en_filt = q.s2[2];  // [R17]
        d.fcnt    = '0;
      end
      else
      begin
        d.fcnt = q.fcnt + 1'b1;
      end
    end
    else
    begin
      d.fcnt = '0;
    end
  end

  // State register; the device starts disabled until enable is seen high.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Conditioned levels for the core.
  assign pins.cmd       = q.s2[1:0];  // [R20]
  assign pins.enable_ok = q.en_filt;
  assign pins.lockout   = q.s2[3];
  assign pins.overtemp  = q.s2[4];
  assign pins.readback  = q.s2[6:5];

endmodule

// file: verif/dcpq_top_sva.sv
// Concurrent checks on the qualifier's pins.
`timescale 1ns/1ps
module dcpq_top_sva #(
  parameter int unsigned QUAL_CYCLES   = 20,
  parameter int unsigned MAX_ON_CYCLES = 100,
  parameter int unsigned FILT_CYCLES   = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic command_input_a,
  input wire logic command_input_b,
  input wire logic enable_in,
  input wire logic supply_low_lockout,
  input wire logic overtemp_shutdown,
  input wire logic coil_drive_a_out,
  input wire logic coil_drive_a_oe_n,
  input wire logic coil_drive_b_out,
  input wire logic coil_drive_b_oe_n
);
  int unsigned hi_a_q, hi_b_q, on_a_q, on_b_q, en_lo_q;
  logic        off;

  assign off = coil_drive_a_oe_n && coil_drive_b_oe_n;

  // Runs of high commands, sinking coils and low enable.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hi_a_q  <= 0;
      hi_b_q  <= 0;
      on_a_q  <= 0;
      on_b_q  <= 0;
      en_lo_q <= 0;
    end
    else
    begin
      hi_a_q  <= command_input_a ? hi_a_q + 1 : 0;
      hi_b_q  <= command_input_b ? hi_b_q + 1 : 0;
      on_a_q  <= coil_drive_a_oe_n ? 0 : on_a_q + 1;
      on_b_q  <= coil_drive_b_oe_n ? 0 : on_b_q + 1;
      en_lo_q <= enable_in ? 0 : en_lo_q + 1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_coils_exclusive: assert property (!(!coil_drive_a_oe_n && !coil_drive_b_oe_n))
    else $error("both coils sinking");
  a_drain_only: assert property (!coil_drive_a_out && !coil_drive_b_out)
    else $error("coil output driven high");
  a_lockout_off: assert property (supply_low_lockout[*4] |-> off)
    else $error("coil on under lockout");
  a_overtemp_off: assert property (overtemp_shutdown[*4] |-> off)
    else $error("coil on in overtemp");
  a_enable_off: assert property (en_lo_q > FILT_CYCLES + 3 |-> off)
    else $error("coil on with enable low");
  a_max_on_a: assert property (on_a_q <= MAX_ON_CYCLES)
    else $error("coil a on too long");
  a_max_on_b: assert property (on_b_q <= MAX_ON_CYCLES)
    else $error("coil b on too long");
  a_qual_a: assert property ($fell(coil_drive_a_oe_n) |-> hi_a_q > QUAL_CYCLES)
    else $error("coil a early");
  a_qual_b: assert property ($fell(coil_drive_b_oe_n) |-> hi_b_q > QUAL_CYCLES)
    else $error("coil b early");

  c_pulse_a: cover property ($fell(coil_drive_a_oe_n));
  c_pulse_b: cover property ($fell(coil_drive_b_oe_n));
  c_capped: cover property (on_a_q == MAX_ON_CYCLES);
endmodule

bind dcpq_top dcpq_top_sva #(
  .QUAL_CYCLES(QUAL_CYCLES), .MAX_ON_CYCLES(MAX_ON_CYCLES), .FILT_CYCLES(FILT_CYCLES)
) i_dcpq_top_sva (
  .hclk(hclk), .hresetn(hresetn), .command_input_a(command_input_a),
  .command_input_b(command_input_b), .enable_in(enable_in),
  .supply_low_lockout(supply_low_lockout), .overtemp_shutdown(overtemp_shutdown),
  .coil_drive_a_out(coil_drive_a_out), .coil_drive_a_oe_n(coil_drive_a_oe_n),
  .coil_drive_b_out(coil_drive_b_out), .coil_drive_b_oe_n(coil_drive_b_oe_n));

// file: verif/dcpq_relay_model.sv
// Dual coil latching relay hung on the two open drain outputs.
`timescale 1ns/1ps
module dcpq_relay_model #(
  parameter int unsigned PULL_CYCLES = 8
) (
  input  wire logic hclk,
  input  wire logic drive_a_out,
  input  wire logic drive_a_oe_n,
  input  wire logic drive_b_out,
  input  wire logic drive_b_oe_n,
  output logic      wire_a,
  output logic      wire_b,
  output logic      contact_closed
);
  int unsigned ton_a = 0;
  int unsigned ton_b = 0;

  // A released drain is pulled up to the coil supply.
  assign wire_a = drive_a_oe_n ? 1'h1 : drive_a_out;
  assign wire_b = drive_b_oe_n ? 1'h1 : drive_b_out;

  // Coil a closes, coil b opens the contact after PULL_CYCLES.
  initial contact_closed = 1'h0;
  always @(posedge hclk)
  begin
    ton_a <= wire_a ? 0 : ton_a + 1;
    ton_b <= wire_b ? 0 : ton_b + 1;
    if (ton_a == PULL_CYCLES)
      contact_closed <= 1'h1;
    if (ton_b == PULL_CYCLES)
      contact_closed <= 1'h0;
  end
endmodule

// file: verif/dcpq_top_bench.sv
// Self-checking bench of the coil pulse qualifier.
`timescale 1ns/1ps
module dcpq_top_bench;
  localparam int unsigned QUAL  = 20;
  localparam int unsigned MAXON = 100;
  localparam int unsigned FILT  = 5;
  localparam int unsigned SETL  = QUAL + MAXON + 10;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic        enable_in, lockout, overtemp, closed;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, cmd, oe, outp, pin, cmd_q, oe_q;
  logic [2:0]  hsize;
  int          miscompares, checks_done;
  int          cyc = 0;
  int          t_rise [2], t_fall [2], width [2], n_pulse [2];

  dcpq_top #(.QUAL_CYCLES(QUAL), .MAX_ON_CYCLES(MAXON), .FIXED_MODE(1'h0), .FILT_CYCLES(FILT))
  i_dcpq_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .command_input_a(cmd[0]), .command_input_b(cmd[1]), .enable_in(enable_in),
    .supply_low_lockout(lockout), .overtemp_shutdown(overtemp),
    .coil_drive_a_in(pin[0]), .coil_drive_a_out(outp[0]), .coil_drive_a_oe_n(oe[0]),
    .coil_drive_b_in(pin[1]), .coil_drive_b_out(outp[1]), .coil_drive_b_oe_n(oe[1]));

  dcpq_relay_model i_dcpq_relay_model (
    .hclk(hclk), .drive_a_out(outp[0]), .drive_a_oe_n(oe[0]), .drive_b_out(outp[1]),
    .drive_b_oe_n(oe[1]), .wire_a(pin[0]), .wire_b(pin[1]), .contact_closed(closed));

  // Free running clock.
  initial
  begin
    hclk = 1'h0;
    forever #2 hclk = ~hclk;
  end

  // Logs command rises and coil edges; ends a hang.
  always @(posedge hclk)
  begin
    cyc++;
    for (int i = 0; i < 2; i++)
    begin
      if (cmd_q[i] === 1'h0 && cmd[i] === 1'h1) t_rise[i] = cyc;
      if (oe_q[i] === 1'h1 && oe[i] === 1'h0)
      begin
        t_fall[i] = cyc;
        n_pulse[i]++;
      end
      if (oe_q[i] === 1'h0 && oe[i] === 1'h1) width[i] = cyc - t_fall[i];
    end
    cmd_q = cmd;
    oe_q  = oe;
    if (cyc > 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  // Compares one value and counts it.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One word transfer; read data lands in rd.
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd = 32'h0000_0000);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= 32'(a);
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  // Raises one command pin for n cycles.
  task automatic pulse(input int ch, input int n);
    @(posedge hclk);
    cmd[ch] <= 1'h1;
    repeat (n) @(posedge hclk);
    cmd[ch] <= 1'h0;
  endtask

  // Waits, bounded, for a coil to sink.
  task automatic wait_on(input int ch);
    for (int k = 0; k < 200 && oe[ch] !== 1'h0; k++) @(posedge hclk);
    check("coil on", oe[ch], 1'h0);
  endtask

  // Checks and clears the event flags.
  task automatic events(input logic [31:0] exp);
    ahb(dcpq_pkg::EVENTS_OFFSET, 1'h0);
    check("events", rd, exp);
    ahb(dcpq_pkg::EVENTS_OFFSET, 1'h1, 32'h0000_000f);
  endtask

  // Reset values, unmapped reads, control write.
  task automatic t_regs();
    ahb(dcpq_pkg::CTRL_OFFSET, 1'h0);
    check("ctrl", rd, 32'h0000_0001);
    ahb(dcpq_pkg::STATUS_OFFSET, 1'h0);
    check("status", rd, 32'h0000_0640);
    ahb(12'h010, 1'h0);
    check("unmapped", rd, 32'h0000_0000);
    ahb(dcpq_pkg::CTRL_OFFSET, 1'h1, 32'h0000_0000);
    ahb(dcpq_pkg::CTRL_OFFSET, 1'h0);
    check("ctrl written", rd, 32'h0000_0000);
    ahb(dcpq_pkg::CTRL_OFFSET, 1'h1, 32'h0000_0001);
    events(32'h0000_0000);
    $display("t_regs done");
  endtask

  // Each input drives its own coil.
  task automatic t_follow();
    for (int ch = 0; ch < 2; ch++)
    begin
      n_pulse = '{0, 0};
      pulse(ch, 40);
      repeat (SETL) @(posedge hclk);
      check("pulses", n_pulse[ch], 1);
      check("other", n_pulse[1 - ch], 0);
      check("delay", t_fall[ch] - t_rise[ch] inside {[QUAL + 2 : QUAL + 6]}, 1'h1);
      check("width", width[ch] inside {[37 : 42]}, 1'h1);
      check("contact", closed, ch == 0);
    end
    $display("t_follow done");
  endtask

  // A short pulse, then a pin held high past the cap.
  task automatic t_short_long();
    n_pulse = '{0, 0};
    pulse(0, QUAL - 4);
    repeat (SETL) @(posedge hclk);
    check("short", n_pulse[0], 0);
    events(32'h0000_0001);
    pulse(0, 250);
    repeat (SETL) @(posedge hclk);
    check("capped", width[0], MAXON);
    check("once", n_pulse[0], 1);
    events(32'h0000_0008);
    $display("t_short_long done");
  endtask

  // Two commands in various overlaps.
  task automatic t_two(input int d0, input int n1, input int exp_a, input logic [31:0] ev);
    n_pulse = '{0, 0};
    fork
      pulse(0, 50);
      begin
        repeat (d0) @(posedge hclk);
        pulse(1, n1);
      end
    join
    repeat (SETL) @(posedge hclk);
    check("a pulses", n_pulse[0], exp_a);
    check("b pulses", n_pulse[1], 0);
    events(ev);
    $display("t_two done");
  endtask

  // Each guard cuts a running pulse.
  task automatic t_guard();
    for (int k = 0; k < 4; k++)
    begin
      n_pulse = '{0, 0};
      fork
        pulse(0, 80);
        begin
          wait_on(0);
          if (k == 0) lockout <= 1'h1;
          if (k == 1) overtemp <= 1'h1;
          if (k == 2) enable_in <= 1'h0;
          if (k == 3) ahb(dcpq_pkg::CTRL_OFFSET, 1'h1, 32'h0000_0000);
          repeat (FILT + 6) @(posedge hclk);
          check("released", oe, 2'h3);
          lockout   <= 1'h0;
          overtemp  <= 1'h0;
          enable_in <= 1'h1;
          if (k == 3) ahb(dcpq_pkg::CTRL_OFFSET, 1'h1, 32'h0000_0001);
        end
      join
      repeat (SETL) @(posedge hclk);
      check("no refire", n_pulse[0], 1);
    end
    $display("t_guard done");
  endtask

  // Main sequence.
  initial
  begin
    hresetn     = 1'h0;
    hsel        = 1'h0;
    haddr       = 32'h0000_0000;
    htrans      = 2'h0;
    hwrite      = 1'h0;
    hsize       = 3'h2;
    hwdata      = 32'h0000_0000;
    cmd         = 2'h0;
    cmd_q       = 2'h0;
    oe_q        = 2'h3;
    enable_in   = 1'h1;
    lockout     = 1'h0;
    overtemp    = 1'h0;
    miscompares = 0;
    checks_done = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (FILT + 10) @(posedge hclk);
    t_regs();
    t_follow();
    t_short_long();
    t_two(QUAL + 15, 20, 1, 32'h0000_0004);
    t_two(5, 8, 1, 32'h0000_0001);
    t_two(0, 50, 0, 32'h0000_0002);
    t_two(5, 50, 0, 32'h0000_0002);
    t_guard();
    summarize();
  end
endmodule
